// [design/ifp_pkg.sv]
// Package of offsets, field positions, reset values and modes for the flag block.
package ifp_pkg;
  // Register offsets.
  localparam logic [7:0] ADDR_PINSEL_LO = 8'h25;
  localparam logic [7:0] ADDR_PINSEL_CLK = 8'h26;
  localparam logic [7:0] ADDR_STAT_RADIO = 8'h27;
  localparam logic [7:0] ADDR_STAT_BUF = 8'h28;
  localparam logic [7:0] ADDR_TRIGGER = 8'h29;
  localparam logic [7:0] ADDR_RX_START_TO = 8'h2A;
  localparam logic [7:0] ADDR_POST_DET_TO = 8'h2B;
  // Reset values.
  localparam logic [11:0] RST_PINSEL = 12'h000;
  localparam logic [2:0] RST_CLKSEL = 3'h7;
  localparam logic [7:0] RST_TRIGGER = 8'hE4;
  localparam logic [7:0] RST_TIMEOUT = 8'h00;
  localparam logic RST_MODE_READY = 1'b1;
  // Radio status bit positions.
  localparam int B_MODE_READY = 7;
  localparam int B_RX_READY = 6;
  localparam int B_TX_READY = 5;
  localparam int B_LOCK = 4;
  localparam int B_STRENGTH = 3;
  localparam int B_TIMEOUT = 2;
  localparam int B_AUTO = 1;
  localparam int B_SYNC = 0;
  // Buffer status bit positions.
  localparam int B_FULL = 7;
  localparam int B_NOT_EMPTY = 6;
  localparam int B_LEVEL = 5;
  localparam int B_OVERRUN = 4;
  localparam int B_SENT = 3;
  localparam int B_PAYLOAD = 2;
  localparam int B_CHECKSUM = 1;
  // Clock-output select codes.
  localparam logic [2:0] CLK_FULL = 3'h0;
  localparam logic [2:0] CLK_RC = 3'h6;
  localparam logic [2:0] CLK_OFF = 3'h7;
  // Bit periods per timeout unit, minus one.
  localparam logic [3:0] BITS_PER_UNIT_M1 = 4'hF;
  // Operating modes as presented on the mode input.
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_FS = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX = 3'h4;
endpackage

// [design/ifp_flags.sv]
// Status flags, pin function selection, clock output and receive timeouts.
// Host side.
// - The register port never stalls.
// - A read answers in the next cycle only.
// - Outside an answer the read data are zero.
// - Both strobes at once are not supported.
//
// Flag timing.
// - Every flag is a flop behind its cause.
// - A cause shows on the bus two cycles on.
// - When a set and a clear meet, set wins, except for mode-ready, ready and sent, where the mode clear wins.
// - Emptying is seen on the count's edge.
// - A flag set on an empty buffer survives.
//
// Overrun clear.
// - A one at bit 4 of the buffer status clears
//   overrun, timeout, sync, payload, checksum.
// - It also pulses the buffer clear output
//   for one cycle, one cycle after the write.
//
// Timeouts.
// - Both count bit ticks, sixteen per unit.
// - A stored zero disables a timer.
// - The receive-start timer arms on entry.
// - The post-detection timer arms on the
//   strength flag's rising edge.
// - A rewrite during a run applies at once.
//
// Limitations.
// - The full-rate clock code is gated logic,
//   so glitches follow any code change.
// - Mode codes on the mode input are local.
// - Pin event tables sit outside this block.
//
// The implementer's own choice: the plain strobed port.
module ifp_flags #(
  parameter int BUF_DEPTH = 66,
  parameter int CNT_W = 7
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [2:0] mode_i,
  input wire logic mode_reached_i,
  input wire logic rx_chain_done_i,
  input wire logic pa_ramp_done_i,
  input wire logic synthesizer_locked_i,
  input wire logic [7:0] measured_signal_strength_i,
  input wire logic strength_valid_i,
  input wire logic intermediate_mode_i,
  input wire logic sync_word_matched_i,
  input wire logic packet_mode_i,
  input wire logic [CNT_W-1:0] buffer_count_i,
  input wire logic [CNT_W-1:0] buffer_level_trigger_i,
  input wire logic buffer_overrun_i,
  input wire logic packet_done_i,
  input wire logic last_byte_i,
  input wire logic checksum_enable_i,
  input wire logic checksum_pass_i,
  input wire logic keep_bad_frame_i,
  input wire logic bit_tick_i,
  input wire logic [23:0] pin_sources_i,
  input wire logic rc_clock_i,
  output logic [5:0] event_pin_o,
  output logic divided_reference_output_o,
  output logic rc_oscillator_enable_o,
  output logic buffer_clear_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  // Writes land at the strobe edge.
  // Reads see the new value one cycle on.
  logic [11:0] pin_select;
  logic [2:0] reference_divider_select;
  logic [7:0] signal_strength_trigger;
  logic [7:0] rx_start_value;
  logic [7:0] post_det_value;

  // Pulls one two-bit pin select field out of the packed vector.
  function automatic logic [1:0] pin_field(input logic [11:0] sel, input int idx);
    pin_field = sel[11-2*idx -: 2];
  endfunction

  // Write decode.
  wire wr_pin_lo = reg_wr_i && (reg_addr_i == ifp_pkg::ADDR_PINSEL_LO);
  wire wr_pin_clk = reg_wr_i && (reg_addr_i == ifp_pkg::ADDR_PINSEL_CLK);
  wire wr_radio = reg_wr_i && (reg_addr_i == ifp_pkg::ADDR_STAT_RADIO);
  wire wr_buf = reg_wr_i && (reg_addr_i == ifp_pkg::ADDR_STAT_BUF);
  wire wr_trig = reg_wr_i && (reg_addr_i == ifp_pkg::ADDR_TRIGGER);
  wire wr_rx_to = reg_wr_i && (reg_addr_i == ifp_pkg::ADDR_RX_START_TO);
  wire wr_pd_to = reg_wr_i && (reg_addr_i == ifp_pkg::ADDR_POST_DET_TO);

  // Host clears, written as ones.
  wire host_clr_strength = wr_radio && reg_wdata_i[ifp_pkg::B_STRENGTH];
  wire host_clr_sync = wr_radio && reg_wdata_i[ifp_pkg::B_SYNC] && !packet_mode_i;
  wire host_clr_overrun = wr_buf && reg_wdata_i[ifp_pkg::B_OVERRUN];

  // Configuration storage; bit 3 of the clock register is not stored.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_select <= ifp_pkg::RST_PINSEL;
      reference_divider_select <= ifp_pkg::RST_CLKSEL;
      signal_strength_trigger <= ifp_pkg::RST_TRIGGER;
      rx_start_value <= ifp_pkg::RST_TIMEOUT;
      post_det_value <= ifp_pkg::RST_TIMEOUT;
    end else begin
      if (wr_pin_lo) pin_select[11:4] <= reg_wdata_i;
      if (wr_pin_clk) pin_select[3:0] <= reg_wdata_i[7:4];
      if (wr_pin_clk) reference_divider_select <= reg_wdata_i[2:0];
      if (wr_trig) signal_strength_trigger <= reg_wdata_i;
      if (wr_rx_to) rx_start_value <= reg_wdata_i;
      if (wr_pd_to) post_det_value <= reg_wdata_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode tracking.
  // Previous mode and count give the edges.
  // Both reset to sleep and empty.
  logic [2:0] mode_prev;
  logic [CNT_W-1:0] count_prev;
  wire in_rx = (mode_i == ifp_pkg::MODE_RX);
  wire in_tx = (mode_i == ifp_pkg::MODE_TX);
  wire in_fs = (mode_i == ifp_pkg::MODE_FS);
  wire in_sleep = (mode_i == ifp_pkg::MODE_SLEEP);
  wire mode_change = (mode_i != mode_prev);
  wire rx_entry = in_rx && (mode_prev != ifp_pkg::MODE_RX);
  // Emptying is an edge, so a flag raised while the buffer is already empty survives.
  wire emptied = (count_prev != '0) && (buffer_count_i == '0);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_prev <= ifp_pkg::MODE_SLEEP;
      count_prev <= '0;
    end else begin
      mode_prev <= mode_i;
      count_prev <= buffer_count_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Radio status flags.
  // Hardware sets them; the host clears strength, timeout and sync.
  // Mode-ready is one after reset.
  logic mode_ready;
  logic rx_ready;
  logic tx_ready;
  logic lock_flag;
  logic strength_flag;
  logic timeout_flag;
  logic auto_flag;
  logic sync_flag;
  logic [1:0] timer_expire;

  // A smaller stored value means a stronger signal, since strength is minus value/2 dBm.
  wire strength_above = strength_valid_i && (measured_signal_strength_i < signal_strength_trigger);
  wire strength_set = in_rx && strength_above && !strength_flag;

  // Mode-ready: the change clears, reached sets only within a stable mode.
  wire next_mode_ready = mode_change ? 1'b0 : (mode_reached_i ? 1'b1 : mode_ready);
  wire next_rx_ready = in_rx && (rx_ready || rx_chain_done_i);
  wire next_tx_ready = in_tx && (tx_ready || pa_ramp_done_i);
  wire next_lock = (in_fs || in_rx || in_tx) && synthesizer_locked_i;
  // Set wins over every clear on all hardware-set flags below.
  wire next_strength = (in_rx && strength_above) ||
                       (strength_flag && in_rx && !host_clr_strength);
  wire next_timeout = (|timer_expire) ||
                      (timeout_flag && in_rx && !emptied && !host_clr_overrun);
  wire next_sync = (in_rx && sync_word_matched_i) ||
                   (sync_flag && in_rx && !emptied && !host_clr_sync && !host_clr_overrun);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ready <= ifp_pkg::RST_MODE_READY;
      rx_ready <= 1'b0;
      tx_ready <= 1'b0;
      lock_flag <= 1'b0;
      strength_flag <= 1'b0;
      timeout_flag <= 1'b0;
      auto_flag <= 1'b0;
      sync_flag <= 1'b0;
    end else begin
      mode_ready <= next_mode_ready;
      rx_ready <= next_rx_ready;
      tx_ready <= next_tx_ready;
      lock_flag <= next_lock;
      strength_flag <= next_strength;
      timeout_flag <= next_timeout;
      auto_flag <= intermediate_mode_i;
      sync_flag <= next_sync;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Buffer and packet flags.
  // Level flags follow the count.
  // Event flags hold until cleared.
  logic full_flag;
  logic not_empty_flag;
  logic level_flag;
  logic overrun_flag;
  logic sent_flag;
  logic payload_flag;
  logic checksum_flag;

  // Without the keep option a bad frame is dropped upstream, so no payload flag.
  wire payload_ok = !checksum_enable_i || keep_bad_frame_i || checksum_pass_i;
  wire payload_set = in_rx && last_byte_i && payload_ok;
  wire checksum_set = in_rx && last_byte_i && checksum_enable_i && checksum_pass_i;
  wire next_overrun = (buffer_overrun_i && !in_sleep) || (overrun_flag && !host_clr_overrun);
  wire next_sent = in_tx && (sent_flag || packet_done_i);
  wire next_payload = payload_set || (payload_flag && !emptied && !host_clr_overrun);
  wire next_checksum = checksum_set || (checksum_flag && !emptied && !host_clr_overrun);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      full_flag <= 1'b0;
      not_empty_flag <= 1'b0;
      level_flag <= 1'b0;
      overrun_flag <= 1'b0;
      sent_flag <= 1'b0;
      payload_flag <= 1'b0;
      checksum_flag <= 1'b0;
      buffer_clear_o <= 1'b0;
    end else begin
      full_flag <= (buffer_count_i == CNT_W'(BUF_DEPTH));
      not_empty_flag <= (buffer_count_i != '0);
      level_flag <= (buffer_count_i > buffer_level_trigger_i);
      overrun_flag <= next_overrun;
      sent_flag <= next_sent;
      payload_flag <= next_payload;
      checksum_flag <= next_checksum;
      buffer_clear_o <= host_clr_overrun;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Two receive timeouts in units of sixteen bit periods.
  // Expiry sets the shared timeout flag.
  // Timer 0 runs from receive entry, timer 1 from the strength event.
  logic [1:0] armed;
  logic [3:0] bit_cnt [2];
  logic [7:0] unit_cnt [2];
  wire [7:0] tmo_value [2];
  wire [1:0] tmo_start;
  wire [1:0] tmo_stop;
  assign tmo_value[0] = rx_start_value;
  assign tmo_value[1] = post_det_value;
  assign tmo_start[0] = rx_entry && (rx_start_value != 8'h00);
  assign tmo_start[1] = strength_set && (post_det_value != 8'h00);
  assign tmo_stop[0] = !in_rx || strength_flag;
  assign tmo_stop[1] = !in_rx || payload_flag;

  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_timer
      wire unit_tick = armed[t] && bit_tick_i && (bit_cnt[t] == ifp_pkg::BITS_PER_UNIT_M1);
      wire hit = unit_tick && (unit_cnt[t] + 8'h01 == tmo_value[t]);
      // Zero disables; the value is read live so a rewrite takes effect at once.
      assign timer_expire[t] = hit && !tmo_stop[t] && (tmo_value[t] != 8'h00);
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          armed[t] <= 1'b0;
          bit_cnt[t] <= 4'h0;
          unit_cnt[t] <= 8'h00;
        end else if (tmo_start[t]) begin
          armed[t] <= 1'b1;
          bit_cnt[t] <= 4'h0;
          unit_cnt[t] <= 8'h00;
        end else if (tmo_stop[t] || hit) begin
          armed[t] <= 1'b0;
        end else if (armed[t] && bit_tick_i) begin
          bit_cnt[t] <= bit_cnt[t] + 4'h1;
          if (unit_tick) unit_cnt[t] <= unit_cnt[t] + 8'h01;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Pin mapping: each pin picks one of four event sources.
  // Pins are flopped so they stay glitch free.
  generate
    for (t = 0; t < 6; t++) begin : g_pin
      wire [3:0] src = pin_sources_i[4*t +: 4];
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) event_pin_o[t] <= 1'b0;
        else event_pin_o[t] <= src[pin_field(pin_select, t)];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Clock output: a free-running divider taps one bit per code.
  // Divider taps give ratios from 2 to 32.
  // The RC code also wakes the oscillator.
  // The full-rate code gates the clock itself, so that path is combinational.
  logic [4:0] div_cnt;
  wire [5:0] div_taps = {div_cnt, 1'b0};
  wire div_sel = (reference_divider_select > ifp_pkg::CLK_FULL) &&
                 (reference_divider_select < ifp_pkg::CLK_RC) ? div_taps[reference_divider_select] : 1'b0;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) div_cnt <= 5'h00;
    else div_cnt <= div_cnt + 5'h01;
  end

  assign rc_oscillator_enable_o = (reference_divider_select == ifp_pkg::CLK_RC);
  assign divided_reference_output_o =
    (reference_divider_select == ifp_pkg::CLK_FULL) ? clock_i :
    (reference_divider_select == ifp_pkg::CLK_RC) ? rc_clock_i :
    (reference_divider_select == ifp_pkg::CLK_OFF) ? 1'b0 : div_sel;

  //////////////////////////////////////////////////////////////////////////////
  // Read path: data stand in the cycle after the strobe, zero otherwise.
  // Unmapped addresses read zero.
  // Unused bits read zero as well.
  wire [7:0] radio_word = {mode_ready, rx_ready, tx_ready, lock_flag,
                           strength_flag, timeout_flag, auto_flag, sync_flag};
  wire [7:0] buf_word = {full_flag, not_empty_flag, level_flag, overrun_flag,
                         sent_flag, payload_flag, checksum_flag, 1'b0};
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr_i)
      ifp_pkg::ADDR_PINSEL_LO: rd_mux = pin_select[11:4];
      ifp_pkg::ADDR_PINSEL_CLK: rd_mux = {pin_select[3:0], 1'b0, reference_divider_select};
      ifp_pkg::ADDR_STAT_RADIO: rd_mux = radio_word;
      ifp_pkg::ADDR_STAT_BUF: rd_mux = buf_word;
      ifp_pkg::ADDR_TRIGGER: rd_mux = signal_strength_trigger;
      ifp_pkg::ADDR_RX_START_TO: rd_mux = rx_start_value;
      ifp_pkg::ADDR_POST_DET_TO: rd_mux = post_det_value;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) reg_rdata_o <= 8'h00;
    else reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
  end

endmodule // ifp_flags

// [bench/ifp_flags_checker.sv]
// Checker for register answers, pin routing and buffer flags of the flag block.
module ifp_flags_checker #(
  parameter int BUF_DEPTH = 66,
  parameter int CNT_W = 7
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [CNT_W-1:0] buffer_count_i,
  input wire logic [CNT_W-1:0] buffer_level_trigger_i,
  input wire logic [23:0] pin_sources_i,
  input wire logic [5:0] event_pin_o,
  input wire logic divided_reference_output_o,
  input wire logic rc_oscillator_enable_o,
  input wire logic buffer_clear_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic [23:0] src_q;
  // Read strobes per register, so the properties stay short.
  wire logic rd25 = reg_rd_i && reg_addr_i == ifp_pkg::ADDR_PINSEL_LO;
  wire logic rd26 = reg_rd_i && reg_addr_i == ifp_pkg::ADDR_PINSEL_CLK;
  wire logic rd28 = reg_rd_i && reg_addr_i == ifp_pkg::ADDR_STAT_BUF;
  // Sources one cycle back, because the pins are registered.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_q <= '0;
    end else begin
      src_q <= pin_sources_i;
    end
  end
  ////////////////////////////////////////
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside an answer");
  unmapped_read_a: assert property (reg_rd_i && (reg_addr_i < 8'h25 || reg_addr_i > 8'h2B) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rc_enable_a: assert property (rd26 |=> rc_oscillator_enable_o == (reg_rdata_o[2:0] == ifp_pkg::CLK_RC))
    else $error("oscillator enable disagrees with select");
  clock_off_a: assert property (rd26 ##1 reg_rdata_o[2:0] == ifp_pkg::CLK_OFF |-> !divided_reference_output_o)
    else $error("clock output not low when off");
  pin_zero_a: assert property (rd25 |=>
    event_pin_o[0] == src_q[reg_rdata_o[7:6]] && event_pin_o[2] == src_q[8 + reg_rdata_o[3:2]])
    else $error("pin 0 or pin 2 does not follow its selected source");
  clear_pulse_a: assert property (buffer_clear_o == $past(reg_wr_i && reg_addr_i == ifp_pkg::ADDR_STAT_BUF && reg_wdata_i[4]))
    else $error("buffer clear pulse wrong");
  buffer_fill_a: assert property (rd28 && $stable(buffer_count_i) |=>
    reg_rdata_o[7:6] == {$past(buffer_count_i) == CNT_W'(BUF_DEPTH), $past(buffer_count_i) != '0} && !reg_rdata_o[0])
    else $error("full or not-empty flag wrong");
  buffer_level_a: assert property (rd28 && $stable(buffer_count_i) && $stable(buffer_level_trigger_i) |=>
    reg_rdata_o[5] == ($past(buffer_count_i) > $past(buffer_level_trigger_i)))
    else $error("level flag wrong");
endmodule // ifp_flags_checker

bind ifp_flags ifp_flags_checker #(.BUF_DEPTH(BUF_DEPTH), .CNT_W(CNT_W)) chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .buffer_count_i(buffer_count_i), .buffer_level_trigger_i(buffer_level_trigger_i),
  .pin_sources_i(pin_sources_i), .event_pin_o(event_pin_o), .divided_reference_output_o(divided_reference_output_o),
  .rc_oscillator_enable_o(rc_oscillator_enable_o), .buffer_clear_o(buffer_clear_o));

// [bench/ifp_host.sv]
// Host model that reads and clears the flags over the register port.
module ifp_host (
  input wire logic clock_i,
  input wire logic [7:0] bus_rdata_i,
  output logic [7:0] bus_addr_o,
  output logic [7:0] bus_wdata_o,
  output logic bus_wr_o,
  output logic bus_rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bus is idle until the first request.
  initial begin
    bus_addr_o = 8'h00;
    bus_wdata_o = 8'h00;
    bus_wr_o = 1'b0;
    bus_rd_o = 1'b0;
  end
  ////////////////////////////////////////
  // One strobe cycle; a one in a clearable flag clears it, so only wanted bits are set.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i) bus_addr_o <= a;
    bus_wdata_o <= d;
    bus_wr_o <= 1'b1;
    @(posedge clock_i) bus_wr_o <= 1'b0;
  endtask
  // The answer stands only in the cycle after the strobe, so it is taken there.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i) bus_addr_o <= a;
    bus_rd_o <= 1'b1;
    @(posedge clock_i) bus_rd_o <= 1'b0;
    #1 d = bus_rdata_i;
  endtask
endmodule // ifp_host

// [bench/tb.sv]
// Self-checking bench for the flag block with a host model on the register port.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] m; logic [7:0] ev; logic w; logic [7:0] a; logic [7:0] d; logic [7:0] x;} ifp_row_t;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] mode_i = ifp_pkg::MODE_SLEEP;
  logic mode_reached_i = 1'b0;
  logic [7:0] measured_signal_strength_i = 8'hFF;
  logic strength_valid_i = 1'b0;
  logic packet_mode_i = 1'b0;
  logic [6:0] buffer_count_i = 7'h00;
  logic [6:0] buffer_level_trigger_i = 7'h0A;
  logic buffer_overrun_i = 1'b0;
  logic bit_tick_i = 1'b0;
  logic [23:0] pin_sources_i = 24'h000000;
  logic rc_clock_i = 1'b0;
  logic [7:0] ev = 8'h00;
  int bad_count = 0;
  int cmp_count = 0;
  wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  wire logic reg_wr_i, reg_rd_i, rx_done, pa_done, locked, inter, sync, sent, last, pass, clk_out, rc_en, buf_clr;
  wire logic [5:0] event_pin_o;
  // Mode, event levels, register access and the expected read value, one row per case.
  ifp_row_t rows [15] = '{{ifp_pkg::MODE_SLEEP, 8'h00, 1'b1, 8'h25, 8'hFF, 8'hFF},
    {ifp_pkg::MODE_SLEEP, 8'h00, 1'b1, 8'h26, 8'hFF, 8'hF7}, {ifp_pkg::MODE_SLEEP, 8'h00, 1'b1, 8'h26, 8'h06, 8'h06},
    {ifp_pkg::MODE_SLEEP, 8'h00, 1'b1, 8'h29, 8'h5A, 8'h5A}, {ifp_pkg::MODE_SLEEP, 8'h00, 1'b1, 8'h2B, 8'h03, 8'h03},
    {ifp_pkg::MODE_SLEEP, 8'h00, 1'b1, 8'h3F, 8'hFF, 8'h00}, {ifp_pkg::MODE_SLEEP, 8'h00, 1'b1, 8'h27, 8'hFF, 8'h80},
    {ifp_pkg::MODE_FS, 8'h04, 1'b0, 8'h27, 8'h00, 8'h10}, {ifp_pkg::MODE_FS, 8'h00, 1'b0, 8'h27, 8'h00, 8'h00},
    {ifp_pkg::MODE_TX, 8'h06, 1'b0, 8'h27, 8'h00, 8'h30}, {ifp_pkg::MODE_TX, 8'h20, 1'b0, 8'h28, 8'h00, 8'h08},
    {ifp_pkg::MODE_RX, 8'h11, 1'b0, 8'h27, 8'h00, 8'h41}, {ifp_pkg::MODE_RX, 8'hC0, 1'b0, 8'h28, 8'h00, 8'h06},
    {ifp_pkg::MODE_STANDBY, 8'h08, 1'b0, 8'h27, 8'h00, 8'h02}, {ifp_pkg::MODE_STANDBY, 8'h00, 1'b0, 8'h27, 8'h00, 8'h00}};
  assign {pass, last, sent, sync, inter, locked, pa_done, rx_done} = ev;
  always #5 clock_i = ~clock_i;
  always #7 rc_clock_i = ~rc_clock_i;
  ifp_host host (.clock_i(clock_i), .bus_rdata_i(reg_rdata_o), .bus_addr_o(reg_addr_i), .bus_wdata_o(reg_wdata_i),
    .bus_wr_o(reg_wr_i), .bus_rd_o(reg_rd_i));
  ifp_flags #(.BUF_DEPTH(66), .CNT_W(7)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mode_i(mode_i),
    .mode_reached_i(mode_reached_i), .rx_chain_done_i(rx_done), .pa_ramp_done_i(pa_done), .synthesizer_locked_i(locked),
    .measured_signal_strength_i(measured_signal_strength_i), .strength_valid_i(strength_valid_i),
    .intermediate_mode_i(inter), .sync_word_matched_i(sync), .packet_mode_i(packet_mode_i),
    .buffer_count_i(buffer_count_i), .buffer_level_trigger_i(buffer_level_trigger_i),
    .buffer_overrun_i(buffer_overrun_i), .packet_done_i(sent), .last_byte_i(last), .checksum_enable_i(1'b1),
    .checksum_pass_i(pass), .keep_bad_frame_i(1'b0), .bit_tick_i(bit_tick_i), .pin_sources_i(pin_sources_i),
    .rc_clock_i(rc_clock_i), .event_pin_o(event_pin_o), .divided_reference_output_o(clk_out),
    .rc_oscillator_enable_o(rc_en), .buffer_clear_o(buf_clr));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Two settling cycles first, since a flag shows one cycle after its cause.
  task automatic rchk(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] d;
    repeat (2) @(posedge clock_i);
    host.rd_reg(a, d);
    check($sformatf("register %h", a), d, x);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clock_i) bit_tick_i <= 1'b1;
      @(posedge clock_i) bit_tick_i <= 1'b0;
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // A hang of ten thousand cycles ends the run as a failure.
  initial begin
    #100000;
    bad_count++;
    final_report();
  end
  ////////////////////////////////////////
  initial begin
    logic [7:0] rv [7];
    logic [6:0] cnt [4];
    logic [7:0] cx [4];
    rv = '{8'h00, 8'h07, 8'h80, 8'h00, 8'hE4, 8'h00, 8'h00};
    cnt = '{7'h42, 7'h0A, 7'h0B, 7'h00};
    cx = '{8'hE6, 8'h46, 8'h66, 8'h00};
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clock_i) mode_i <= rows[i].m;
      ev <= rows[i].ev;
      if (rows[i].w) begin
        host.wr_reg(rows[i].a, rows[i].d);
      end
      rchk(rows[i].a, rows[i].x);
      @(posedge clock_i) ev <= 8'h00;
    end
    @(posedge clock_i) mode_reached_i <= 1'b1;
    @(posedge clock_i) mode_reached_i <= 1'b0;
    rchk(8'h27, 8'h80);
    @(posedge clock_i) mode_i <= ifp_pkg::MODE_SLEEP;
    rchk(8'h27, 8'h00);
    // Full boundary, level equal to the trigger, one above, then emptied.
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i) buffer_count_i <= cnt[i];
      rchk(8'h28, cx[i]);
    end
    @(posedge clock_i) rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    foreach (rv[i])
      rchk(8'h25 + 8'(i), rv[i]);
    @(posedge clock_i) mode_i <= ifp_pkg::MODE_STANDBY;
    @(posedge clock_i) buffer_overrun_i <= 1'b1;
    @(posedge clock_i) buffer_overrun_i <= 1'b0;
    rchk(8'h28, 8'h10);
    host.wr_reg(8'h28, 8'h10);
    rchk(8'h28, 8'h00);
    @(posedge clock_i) mode_i <= ifp_pkg::MODE_SLEEP;
    @(posedge clock_i) buffer_overrun_i <= 1'b1;
    @(posedge clock_i) buffer_overrun_i <= 1'b0;
    rchk(8'h28, 8'h00);
    // Receive-start timeout of one unit: silent after 15 bit periods, set after 16.
    host.wr_reg(8'h2A, 8'h01);
    @(posedge clock_i) mode_i <= ifp_pkg::MODE_RX;
    ticks(15);
    rchk(8'h27, 8'h00);
    ticks(1);
    rchk(8'h27, 8'h04);
    @(posedge clock_i) mode_i <= ifp_pkg::MODE_STANDBY;
    rchk(8'h27, 8'h00);
    host.wr_reg(8'h2A, 8'h00);
    host.wr_reg(8'h2B, 8'h01);
    @(posedge clock_i) mode_i <= ifp_pkg::MODE_RX;
    measured_signal_strength_i <= 8'hE4;
    strength_valid_i <= 1'b1;
    rchk(8'h27, 8'h00);
    @(posedge clock_i) measured_signal_strength_i <= 8'hE3;
    rchk(8'h27, 8'h08);
    @(posedge clock_i) strength_valid_i <= 1'b0;
    ticks(15);
    rchk(8'h27, 8'h08);
    ticks(1);
    rchk(8'h27, 8'h0C);
    host.wr_reg(8'h27, 8'h08);
    rchk(8'h27, 8'h04);
    // Sync flag ignores the host in packet mode and obeys it in continuous mode.
    @(posedge clock_i) packet_mode_i <= 1'b1;
    ev <= 8'h10;
    @(posedge clock_i) ev <= 8'h00;
    host.wr_reg(8'h27, 8'h01);
    rchk(8'h27, 8'h05);
    @(posedge clock_i) packet_mode_i <= 1'b0;
    host.wr_reg(8'h27, 8'h01);
    rchk(8'h27, 8'h04);
    host.wr_reg(8'h25, 8'h80);
    host.wr_reg(8'h26, 8'h47);
    @(posedge clock_i) pin_sources_i <= 24'h020004;
    rchk(8'h25, 8'h80);
    check("event pins", {2'b00, event_pin_o}, 8'h11);
    check("clock output", {7'h00, clk_out}, 8'h00);
    final_report();
  end
endmodule // tb
